/* File: hw/acio_chan_seq.sv */
// Input channel sequencer: steps to the next enabled channel per scan
`timescale 1ns/1ps
module acio_chan_seq
    import acio_pkg::*;
#(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // Control
    input  wire logic                 advance,
    input  wire logic [N-1:0]         en_mask,
    // Current channel
    output logic      [$clog2(N)-1:0] cur_idx
);

    logic [$clog2(N)-1:0] nxt;

    // Empty mask falls back to channel 1 so the code never freezes mid-list
    always_comb begin
        logic [$clog2(N)-1:0] cand;
        nxt  = '0;
        cand = '0;
        for (int k = N; k >= 1; k--) begin
            cand = ($clog2(N))'((int'(cur_idx) + k) % N);
            if (en_mask[cand]) begin
                nxt = cand;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_idx <= '0;
        end else if (advance) begin
            cur_idx <= nxt;
        end
    end

endmodule

/* File: hw/acio_out_upd.sv */
// Output channel holders: each loads its value when told to apply
`timescale 1ns/1ps
module acio_out_upd
    import acio_pkg::*;
#(
    parameter int N = 2,
    parameter int W = 12
) (
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // Update request
    input  wire logic [N-1:0] apply,
    input  wire logic [W-1:0] val   [N],
    // Converter values
    output logic      [W-1:0] dac   [N]
);

    for (genvar g = 0; g < N; g++) begin : g_ch
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                dac[g] <= W'(DAC_RST);
            end else if (apply[g]) begin
                dac[g] <= val[g];
            end
        end
    end

endmodule

/* File: hw/acio_pkg.sv */
// Shared constants and types of the analog combo I/O word interface
package acio_pkg;

    // ------------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------------
    localparam int          DATA_W      = 12;
    localparam int          WORD_W      = 16;
    localparam int          N_IN        = 4;
    localparam int          N_OUT       = 2;
    localparam int          IDX_W       = 2;
    localparam int          PT_A_BIT    = 12;
    localparam int          PT_B_BIT    = 13;
    localparam int          BUSY_BIT    = 14;
    localparam int          FAIL_BIT    = 15;
    localparam int          SEL1_BIT    = 12;
    localparam int          SEL2_BIT    = 13;
    localparam logic [11:0] FULL_SCALE  = 12'hFFF;
    localparam logic [15:0] PTR_BUSY    = 16'h8000;
    localparam logic [15:0] IN_WORD_RST = 16'h4000;
    localparam logic [11:0] DAC_RST     = 12'h000;

    // ------------------------------------------------------------------
    // Register map (byte offsets) and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFF_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_STATUS  = 8'h04;
    localparam logic [7:0]  OFF_IN_PTR  = 8'h10;
    localparam logic [7:0]  OFF_OUT_PTR = 8'h20;
    localparam int          CTRL_PTR    = 0;
    localparam int          CTRL_EN_LO  = 4;
    localparam logic [3:0]  EN_RST      = 4'hF;
    localparam logic        PTR_RST     = 1'b0;

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_START = 2'b01,
        ST_RUN   = 2'b10
    } acio_run_t;

    typedef enum logic [1:0] {
        AHB_IDLE = 2'b01,
        AHB_WAIT = 2'b10
    } acio_ahb_t;

endpackage

/* File: hw/acio_top.sv */
// Backplane word interface of the four-in, two-out analog combo module
//
// How it works
// - One sixteen-bit input, one output word
// - Low twelve input bits carry unsigned sample
// - Two points encode active input channel
// - Channel code advances each scan, wraps
// - Top two points: busy, then failure
// - Busy forced during first scan
// - Busy afterwards flags noisy conversion
// - Pointer words report busy as 8000
// - Failure flags missing supply, loose connector
// - Data reads zero while failure shown
// - One module-wide failure flag, self-clearing
// - Active-low selects choose updated channels
// - Both low: both; both high: hold
// - Twelve-bit counts, 000 through FFF
// - Range ends map to 0 and 4095
// - Pointer mode applies both outputs each scan
// - Multiplexed input skips disabled channels
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module acio_top
    import acio_pkg::*;
(
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Backplane scan
    input  wire logic              scan_tick,
    output logic      [WORD_W-1:0] in_word,
    input  wire logic [WORD_W-1:0] out_word,
    // Converter side
    input  wire logic [DATA_W-1:0] adc_sample [N_IN],
    input  wire logic              noise_detect,
    input  wire logic              supply_missing,
    input  wire logic              connector_loose,
    output logic      [DATA_W-1:0] dac_value  [N_OUT]
);

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    acio_run_t           run_q;
    acio_ahb_t           ahb_q;
    logic                ptr_mode_q;
    logic [N_IN-1:0]     en_mask_q;
    logic [DATA_W-1:0]   out_ptr_q [N_OUT];
    logic [WORD_W-1:0]   ptr_word_q [N_IN];
    logic [WORD_W-1:0]   in_word_q;
    logic [7:0]          dp_addr_q;
    logic                dp_write_q;
    logic [31:0]         hrdata_q;
    logic                hreadyout_q;
    logic                hresp_q;
    logic [IDX_W-1:0]    cur_idx;
    logic                busy_now;
    logic                fail_now;
    logic [DATA_W-1:0]   cur_sample;
    logic [N_OUT-1:0]    apply;
    logic [DATA_W-1:0]   upd_val [N_OUT];
    logic [N_OUT-1:0]    sel_n;
    logic [31:0]         rd_data;

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = hresp_q;
    assign in_word   = in_word_q;

    // ------------------------------------------------------------------
    // Diagnostics
    // ------------------------------------------------------------------
    // Failure follows its causes live, so it drops on its own once they go
    assign fail_now = supply_missing | connector_loose;
    assign busy_now = (run_q == ST_START) | noise_detect;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q <= ST_START;
        end else begin
            unique case (run_q)
                ST_START: begin
                    if (scan_tick) begin
                        run_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    run_q <= ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Input channel sequencing and input word
    // ------------------------------------------------------------------
    acio_chan_seq #(
        .N       (N_IN)
    ) u_seq (
        .hclk    (hclk),
        .hresetn (hresetn),
        .advance (scan_tick),
        .en_mask (en_mask_q),
        .cur_idx (cur_idx)
    );

    // Samples are already converter counts; scaling is fixed in the front end
    assign cur_sample = adc_sample[cur_idx] & FULL_SCALE;

    // Whole word loads in one edge so data never pairs with a stale code
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_word_q <= IN_WORD_RST;
        end else if (scan_tick) begin
            in_word_q[DATA_W-1:0] <= fail_now ? '0 : cur_sample;
            in_word_q[PT_A_BIT]   <= cur_idx[1];
            in_word_q[PT_B_BIT]   <= cur_idx[0];
            in_word_q[BUSY_BIT]   <= busy_now;
            in_word_q[FAIL_BIT]   <= fail_now;
        end
    end

    // ------------------------------------------------------------------
    // Pointer words, one per input channel
    // ------------------------------------------------------------------
    for (genvar g = 0; g < N_IN; g++) begin : g_ptr
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ptr_word_q[g] <= PTR_BUSY;
            end else if (scan_tick && en_mask_q[g]) begin
                if (busy_now) begin
                    ptr_word_q[g] <= PTR_BUSY;
                end else if (fail_now) begin
                    ptr_word_q[g] <= '0;
                end else begin
                    ptr_word_q[g] <= {4'h0, adc_sample[g] & FULL_SCALE};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Output channel update
    // ------------------------------------------------------------------
    assign sel_n = {out_word[SEL2_BIT], out_word[SEL1_BIT]};

    always_comb begin
        for (int k = 0; k < N_OUT; k++) begin
            if (ptr_mode_q) begin
                apply[k]   = scan_tick;
                upd_val[k] = out_ptr_q[k];
            end else begin
                apply[k]   = scan_tick & ~sel_n[k];
                upd_val[k] = out_word[DATA_W-1:0];
            end
        end
    end

    acio_out_upd #(
        .N       (N_OUT),
        .W       (DATA_W)
    ) u_upd (
        .hclk    (hclk),
        .hresetn (hresetn),
        .apply   (apply),
        .val     (upd_val),
        .dac     (dac_value)
    );

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    // One wait state per transfer lets a read follow a write with fresh data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ahb_q       <= AHB_IDLE;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
            dp_addr_q   <= '0;
            dp_write_q  <= 1'b0;
        end else begin
            unique case (ahb_q)
                AHB_IDLE: begin
                    if (hsel && htrans[1] && hready) begin
                        ahb_q       <= AHB_WAIT;
                        hreadyout_q <= 1'b0;
                        dp_addr_q   <= haddr[7:0];
                        dp_write_q  <= hwrite;
                    end
                end
                AHB_WAIT: begin
                    ahb_q       <= AHB_IDLE;
                    hreadyout_q <= 1'b1;
                end
            endcase
        end
    end

    always_comb begin
        rd_data = '0;
        case (dp_addr_q)
            OFF_CTRL:          rd_data = {24'h0, en_mask_q, 3'h0, ptr_mode_q};
            OFF_STATUS:        rd_data = {28'h0, in_word_q[FAIL_BIT],
                                          in_word_q[BUSY_BIT], cur_idx};
            OFF_IN_PTR:        rd_data = {16'h0, ptr_word_q[0]};
            OFF_IN_PTR + 8'h4: rd_data = {16'h0, ptr_word_q[1]};
            OFF_IN_PTR + 8'h8: rd_data = {16'h0, ptr_word_q[2]};
            OFF_IN_PTR + 8'hC: rd_data = {16'h0, ptr_word_q[3]};
            OFF_OUT_PTR:       rd_data = {20'h0, out_ptr_q[0]};
            OFF_OUT_PTR + 8'h4: rd_data = {20'h0, out_ptr_q[1]};
            default:           rd_data = '0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= '0;
        end else if (ahb_q == AHB_WAIT && !dp_write_q) begin
            hrdata_q <= rd_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_mode_q <= PTR_RST;
            en_mask_q  <= EN_RST;
        end else if (ahb_q == AHB_WAIT && dp_write_q && dp_addr_q == OFF_CTRL) begin
            ptr_mode_q <= hwdata[CTRL_PTR];
            en_mask_q  <= hwdata[CTRL_EN_LO +: N_IN];
        end
    end

    for (genvar g = 0; g < N_OUT; g++) begin : g_optr
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                out_ptr_q[g] <= DAC_RST;
            end else if (ahb_q == AHB_WAIT && dp_write_q &&
                         dp_addr_q == OFF_OUT_PTR + 8'(4 * g)) begin
                out_ptr_q[g] <= hwdata[DATA_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence scan_ev;
        scan_tick;
    endsequence

    sequence first_scan;
        scan_tick && run_q == ST_START;
    endsequence

    sequence mux_scan;
        scan_tick && !ptr_mode_q;
    endsequence

    word_fail_zero_a: assert property (
        in_word_q[FAIL_BIT] |-> in_word_q[DATA_W-1:0] == '0)
        else $error("data not zero while failure shown");

    first_busy_a: assert property (
        first_scan |=> in_word_q[BUSY_BIT] && run_q == ST_RUN)
        else $error("busy missing on first scan");

    noise_busy_a: assert property (
        scan_ev and noise_detect |=> in_word_q[BUSY_BIT])
        else $error("noise did not raise busy");

    code_step_a: assert property (
        scan_ev and en_mask_q == 4'hF |=> cur_idx == $past(cur_idx) + 2'd1)
        else $error("channel code did not step");

    skip_chan_a: assert property (
        scan_ev and en_mask_q == 4'h5 and cur_idx == 2'd0 |=> cur_idx == 2'd2)
        else $error("disabled channel not skipped");

    word_pair_a: assert property (
        scan_ev and !fail_now |=> in_word_q[DATA_W-1:0] == $past(cur_sample)
            && {in_word_q[PT_A_BIT], in_word_q[PT_B_BIT]} == $past(cur_idx))
        else $error("data paired with wrong channel code");

    fail_clear_a: assert property (
        scan_ev and !fail_now |=> !in_word_q[FAIL_BIT])
        else $error("failure did not clear");

    ptr_busy_a: assert property (
        scan_ev and busy_now and en_mask_q[0] |=> ptr_word_q[0] == PTR_BUSY)
        else $error("pointer word not 8000 while busy");

    hold_none_a: assert property (
        mux_scan and sel_n == 2'b11 |=> $stable(dac_value[0]) && $stable(dac_value[1]))
        else $error("output changed with no channel selected");

    both_same_a: assert property (
        mux_scan and sel_n == 2'b00 |=> dac_value[0] == dac_value[1]
            && dac_value[0] == $past(out_word[DATA_W-1:0]))
        else $error("both channels not loaded alike");

    ptr_apply_a: assert property (
        scan_ev and ptr_mode_q |=> dac_value[0] == $past(out_ptr_q[0])
            && dac_value[1] == $past(out_ptr_q[1]))
        else $error("pointer outputs not applied in scan");

    ahb_answer_a: assert property (
        ahb_q == AHB_IDLE && hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
        else $error("bus answer timing wrong");

    fail_flag_a: assert property (
        scan_ev |=> in_word_q[FAIL_BIT] == $past(fail_now))
        else $error("failure flag does not follow its causes");

    ptr_fail_a: assert property (
        scan_ev and !busy_now and fail_now and en_mask_q[3] |=> ptr_word_q[3] == '0)
        else $error("pointer word not zero while failed");

    sel_one_a: assert property (
        mux_scan and sel_n == 2'b10 |=> $stable(dac_value[1])
            && dac_value[0] == $past(out_word[DATA_W-1:0]))
        else $error("first output select not honoured");

    sel_two_a: assert property (
        mux_scan and sel_n == 2'b01 |=> $stable(dac_value[0])
            && dac_value[1] == $past(out_word[DATA_W-1:0]))
        else $error("second output select not honoured");

    word_hold_a: assert property (
        !scan_tick |=> $stable(in_word_q))
        else $error("input word changed between scans");

    ahb_idle_a: assert property (
        ahb_q == AHB_IDLE && !(hsel && htrans[1] && hready) |=> hreadyout && !hresp)
        else $error("bus not ready while idle");

endmodule

/* File: testbench/acio_host_model.sv */
// Host scan model: output word and one scan pulse per host scan
`timescale 1ns/1ps
module acio_host_model
    import acio_pkg::*;
(
    // Clock
    input  wire logic              hclk,
    // Scan outputs
    output logic                   scan_tick,
    output logic      [WORD_W-1:0] out_word
);
    initial begin
        scan_tick = 1'b0;
        out_word  = 16'h3000;
    end

    // ------------------------------------------------------------------
    // One scan
    // ------------------------------------------------------------------
    // One channel value per scan; selects are active low
    task automatic scan(input logic [11:0] v, input logic s1_n, input logic s2_n);
        @(posedge hclk);
        out_word  <= {2'b00, s2_n, s1_n, v};
        scan_tick <= 1'b1;
        @(posedge hclk);
        scan_tick <= 1'b0;
        // Word is unsampled between scans: show its inverse, never a stale copy
        out_word  <= ~{2'b00, s2_n, s1_n, v};
    endtask
endmodule

/* File: testbench/acio_top_test.sv */
// Self-checking bench of the analog combo I/O word interface
`timescale 1ns/1ps
module acio_top_test
    import acio_pkg::*;
;
    logic              hclk = 1'b0;
    logic              hresetn;
    logic              hsel;
    logic [31:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [31:0]       hwdata;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
    logic              scan_tick;
    logic [WORD_W-1:0] in_word;
    logic [WORD_W-1:0] out_word;
    logic [DATA_W-1:0] adc [N_IN];
    logic              noise;
    logic              sup;
    logic              conn;
    logic [DATA_W-1:0] dac_value [N_OUT];
    int                n_mismatch;
    int                num_checks;
    logic [1:0]        cur;
    logic [3:0]        mask;
    logic              first;
    logic              ptrm;
    logic [11:0]       exp_d0, exp_d1, optr0, optr1;
    logic [11:0]       vt [6];
    logic [1:0]        st [6];

    always #5 hclk = ~hclk;

    acio_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .scan_tick(scan_tick), .in_word(in_word), .out_word(out_word),
        .adc_sample(adc), .noise_detect(noise), .supply_missing(sup),
        .connector_loose(conn), .dac_value(dac_value));

    acio_host_model host_u (.hclk(hclk), .scan_tick(scan_tick), .out_word(out_word));

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Bus access
    // ------------------------------------------------------------------
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                n_mismatch++;
                print_verdict();
            end
            @(posedge hclk);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        hsel   <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, a, 32'h0, rd);
        chk(nm, rd, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        ahb(1'b1, a, d, rd);
    endtask

    // ------------------------------------------------------------------
    // Scan and converter side
    // ------------------------------------------------------------------
    // Next enabled channel after c; an empty mask falls back to channel 1
    function automatic logic [1:0] nxt(input logic [1:0] c, input logic [3:0] m);
        logic [1:0] j;
        nxt = 2'd0;
        for (int k = 4; k >= 1; k--) begin
            j = c + k[1:0];
            if (m[j]) nxt = j;
        end
    endfunction

    task automatic conv(input logic n, input logic s, input logic c);
        @(posedge hclk);
        noise <= n;
        sup   <= s;
        conn  <= c;
        // Let the new levels settle before scan_chk forms its expected word
        #1;
    endtask

    task automatic scan_chk(input logic [11:0] v, input logic s1n, input logic s2n);
        logic        fl;
        logic [15:0] ew;
        fl = sup | conn;
        ew = {fl, first | noise, cur[0], cur[1], fl ? 12'h000 : adc[cur]};
        if (ptrm) begin
            exp_d0 = optr0;
            exp_d1 = optr1;
        end else begin
            if (!s1n) exp_d0 = v;
            if (!s2n) exp_d1 = v;
        end
        host_u.scan(v, s1n, s2n);
        #1;
        chk("in_word", {16'h0, in_word}, {16'h0, ew});
        chk("dac1", {20'h0, dac_value[0]}, {20'h0, exp_d0});
        chk("dac2", {20'h0, dac_value[1]}, {20'h0, exp_d1});
        cur   = nxt(cur, mask);
        first = 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        noise = 1'b0;
        sup = 1'b0;
        conn = 1'b0;
        adc = '{12'hFFF, 12'h000, 12'h800, 12'h001};
        vt = '{12'hFFF, 12'h001, 12'hABC, 12'h555, 12'h000, 12'h800};
        st = '{2'b10, 2'b01, 2'b00, 2'b11, 2'b11, 2'b00};
        n_mismatch = 0;
        num_checks = 0;
        cur = 2'd0;
        mask = 4'hF;
        first = 1'b1;
        ptrm = 1'b0;
        exp_d0 = 12'h0;
        exp_d1 = 12'h0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk("in_word rst", {16'h0, in_word}, 32'h0000_4000);
        rdchk("ctrl rst", OFF_CTRL, 32'h0000_00F0);
        rdchk("ptr1 rst", OFF_IN_PTR, 32'h0000_8000);
        // Six scans wrap the channel code; every select pairing at least once
        for (int k = 0; k < 6; k++) scan_chk(vt[k], st[k][0], st[k][1]);
        rdchk("status", OFF_STATUS, {30'h0, cur});
        rdchk("ptr1", OFF_IN_PTR, 32'h0000_0FFF);
        rdchk("ptr3", OFF_IN_PTR + 8'h08, 32'h0000_0800);
        // Noise on channel 3, then failures on channels 4 and 1
        conv(1'b1, 1'b0, 1'b0);
        scan_chk(12'h000, 1'b1, 1'b1);
        rdchk("ptr3 busy", OFF_IN_PTR + 8'h08, 32'h0000_8000);
        conv(1'b0, 1'b1, 1'b0);
        scan_chk(12'h000, 1'b1, 1'b1);
        rdchk("ptr4 fail", OFF_IN_PTR + 8'h0C, 32'h0000_0000);
        conv(1'b0, 1'b0, 1'b1);
        scan_chk(12'h000, 1'b1, 1'b1);
        conv(1'b0, 1'b0, 1'b0);
        scan_chk(12'h000, 1'b1, 1'b1);
        // Only channels 1 and 3 enabled
        wr(OFF_CTRL, 32'h0000_0050);
        mask = 4'h5;
        rdchk("ctrl", OFF_CTRL, 32'h0000_0050);
        for (int k = 0; k < 4; k++) scan_chk(12'h000, 1'b1, 1'b1);
        // Pointer mode applies both outputs whatever the selects say
        wr(OFF_OUT_PTR, 32'h0000_0123);
        wr(OFF_OUT_PTR + 8'h04, 32'h0000_0FFF);
        rdchk("optr2", OFF_OUT_PTR + 8'h04, 32'h0000_0FFF);
        wr(OFF_CTRL, 32'h0000_0051);
        ptrm = 1'b1;
        optr0 = 12'h123;
        optr1 = 12'hFFF;
        scan_chk(12'h777, 1'b1, 1'b1);
        wr(OFF_OUT_PTR, 32'h0000_0000);
        optr0 = 12'h000;
        scan_chk(12'h777, 1'b0, 1'b0);
        // Unmapped place reads zero and ignores writes
        wr(8'h40, 32'hFFFF_FFFF);
        rdchk("unmapped", 8'h40, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        print_verdict();
    end
endmodule
